/* rsb_flag_if.sv */
// Carrier between the bank and its packet flag tracker.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rsb_flag_if;
    logic crc_check_done;
    logic crc_match;
    logic rx_entry;
    logic sync_word_done;
    logic packet_end;
    logic rx_mode;
    logic tx_mode;
    logic address_fail;
    logic rx_overflow_state;
    logic tx_underflow_state;
    logic crc_ok;
    logic sync_found;

    modport source
    (
        output crc_check_done, crc_match, rx_entry, sync_word_done,
        output packet_end, rx_mode, tx_mode, address_fail,
        output rx_overflow_state, tx_underflow_state,
        input crc_ok, sync_found
    );

    modport tracker
    (
        input crc_check_done, crc_match, rx_entry, sync_word_done,
        input packet_end, rx_mode, tx_mode, address_fail,
        input rx_overflow_state, tx_underflow_state,
        output crc_ok, sync_found
    );
endinterface

/* rsb_host_model.sv */
// Host model driving the serial configuration port of the status bank.
// Assumes the bank samples the port on clk_sys and needs two cycles a phase.
`timescale 1ns/1ps
module rsb_host_model
(
    input wire logic clk_sys,
    output logic spi_csn,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    import rsb_pkg::*;

    // Idle levels: deselected with the clock low, so every frame starts clean.
    initial
    begin
        spi_csn = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    // Wait n clock edges, then move off the edge by the bench skew.
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    // One frame: a header byte out, then one data byte in, MSB first.
    // Each sclk phase lasts three cycles, one more than the bank needs.
    // host reads bytes only, never polls output bits for lock
    task automatic xfer(input rsb_byte_type hdr, output rsb_byte_type data,
        output logic drove);
        int i;
        data = BYTE_ZERO;
        drove = 1'b0;
        spi_csn = 1'b0;
        step(2);
        for (i = 7; i >= 0; i--)
        begin
            spi_mosi = hdr[i];
            step(3);
            spi_sclk = 1'b1;
            step(3);
            spi_sclk = 1'b0;
        end
        for (i = 7; i >= 0; i--)
        begin
            // The line is unused now; toggling it hides no stale value.
            spi_mosi = ~spi_mosi;
            step(3);
            // A released line reads as the inverse of its last value, so
            // a byte that is not driven throughout cannot match.
            data[i] = spi_miso_oe ? spi_miso : ~spi_miso;
            drove = drove | spi_miso_oe;
            spi_sclk = 1'b1;
            step(3);
            spi_sclk = 1'b0;
        end
        step(3);
        spi_csn = 1'b1;
        step(3);
    endtask
endmodule

/* rsb_pkg.sv */
// Constants and types shared by the radio status register bank.
// Assumes a byte-wide serial configuration port and 6-bit register addresses.
package rsb_pkg;

    // One register byte and one fill count as carried on the ports.
    typedef logic [7:0] rsb_byte_type;
    typedef logic [6:0] rsb_fill_type;
    typedef logic [15:0] rsb_timer_type;
    typedef logic [5:0] rsb_addr_type;

    // Serial port walk; Gray codes along idle, header, data, ignore.
    typedef enum logic [1:0]
    {
        RSB_IDLE = 2'b00,
        RSB_HEADER = 2'b01,
        RSB_DATA = 2'b11,
        RSB_IGNORE = 2'b10
    } rsb_spi_state_type;

    // Register offsets of the status bank.
    localparam rsb_addr_type REG_WAKE_HIGH = 6'h36;
    localparam rsb_addr_type REG_WAKE_LOW = 6'h37;
    localparam rsb_addr_type REG_PKT_STATUS = 6'h38;
    localparam rsb_addr_type REG_SYNTH_DAC = 6'h39;
    localparam rsb_addr_type REG_TX_COUNT = 6'h3a;
    localparam rsb_addr_type REG_RX_COUNT = 6'h3b;
    localparam rsb_addr_type REG_RC_CAL_ONE = 6'h3c;
    localparam rsb_addr_type REG_RC_CAL_ZERO = 6'h3d;

    // Header byte layout: read flag, burst flag, address in the low bits.
    localparam logic [2:0] HDR_READ_BIT = 3'h7;
    localparam logic [2:0] HDR_BURST_BIT = 3'h6;

    // Packet status field positions.
    localparam logic [2:0] PS_CRC_OK = 3'h7;
    localparam logic [2:0] PS_CARRIER = 3'h6;
    localparam logic [2:0] PS_PREAMBLE = 3'h5;
    localparam logic [2:0] PS_CLEAR = 3'h4;
    localparam logic [2:0] PS_SYNC = 3'h3;
    localparam logic [2:0] PS_OUT_TWO = 3'h2;
    localparam logic [2:0] PS_RESERVED = 3'h1;
    localparam logic [2:0] PS_OUT_ZERO = 3'h0;

    // Flag position in both fill count registers.
    localparam logic [2:0] COUNT_FLAG = 3'h7;

    // Bit counting within one serial byte.
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam rsb_byte_type BYTE_ZERO = 8'h00;

endpackage

/* rsb_status_bank.sv */
// Read-only radio status bank behind the serial configuration port.
// Assumes port pins are synchronous to clk_sys and the serial clock runs
// at most a quarter of clk_sys, so every serial edge is seen.
`timescale 1ns/1ps
module rsb_status_bank
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire rsb_pkg::rsb_timer_type wake_timer,
    input wire logic crc_check_done,
    input wire logic crc_match,
    input wire logic rx_entry,
    input wire logic sync_word_done,
    input wire logic packet_end,
    input wire logic rx_mode,
    input wire logic tx_mode,
    input wire logic address_fail,
    input wire logic rx_overflow_state,
    input wire logic tx_underflow_state,
    input wire logic carrier_sense,
    input wire logic preamble_quality_met,
    input wire logic channel_clear,
    input wire logic general_output_two,
    input wire logic general_output_zero,
    input wire rsb_pkg::rsb_byte_type synth_cal_dac_readout,
    input wire logic transmit_fifo_underrun,
    input wire rsb_pkg::rsb_fill_type transmit_fill_level,
    input wire logic receive_fifo_overrun,
    input wire rsb_pkg::rsb_fill_type receive_fill_level,
    input wire rsb_pkg::rsb_fill_type rc_cal_result_one,
    input wire rsb_pkg::rsb_fill_type rc_cal_result_zero
);
    import rsb_pkg::*;

    rsb_flag_if flags ();

    rsb_spi_state_type state;
    rsb_spi_state_type next_state;
    logic sclk_prev;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    rsb_byte_type hdr_shift;
    rsb_byte_type next_hdr_shift;
    rsb_byte_type out_shift;
    rsb_byte_type next_out_shift;
    rsb_byte_type header_byte;
    rsb_byte_type pkt_status;
    rsb_byte_type selected;
    rsb_addr_type header_addr;
    logic sclk_rise;
    logic sclk_fall;
    logic hdr_done;
    logic take_read;

    // True for the addresses that this bank answers.
    function automatic logic is_ours(input rsb_addr_type addr);
        is_ours = (addr >= REG_WAKE_HIGH) && (addr <= REG_RC_CAL_ZERO);
    endfunction

    // True for a header that asks for a burst read of a status register.
    function automatic logic is_status_read(input rsb_byte_type hdr);
        is_status_read = hdr[HDR_READ_BIT] && hdr[HDR_BURST_BIT] &&
                         is_ours(hdr[5:0]);
    endfunction

    // Event and mode signals handed to the flag tracker.
    assign flags.crc_check_done = crc_check_done;
    assign flags.crc_match = crc_match;
    assign flags.rx_entry = rx_entry;
    assign flags.sync_word_done = sync_word_done;
    assign flags.packet_end = packet_end;
    assign flags.rx_mode = rx_mode;
    assign flags.tx_mode = tx_mode;
    assign flags.address_fail = address_fail;
    assign flags.rx_overflow_state = rx_overflow_state;
    assign flags.tx_underflow_state = tx_underflow_state;

    rsb_sync_tracker u_tracker
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .flags(flags)
    );

    // Packet status byte; outputs are taken before any pin inversion,
    // so the host sees the raw selected signal whatever its polarity.
    always_comb
    begin
        pkt_status = BYTE_ZERO;
        pkt_status[PS_CRC_OK] = flags.crc_ok;
        pkt_status[PS_SYNC] = flags.sync_found;
        pkt_status[PS_CARRIER] = carrier_sense;
        pkt_status[PS_PREAMBLE] = preamble_quality_met;
        pkt_status[PS_CLEAR] = channel_clear;
        pkt_status[PS_OUT_TWO] = general_output_two;
        pkt_status[PS_RESERVED] = 1'b0;
        pkt_status[PS_OUT_ZERO] = general_output_zero;
    end

    // Serial edge detection; pins are already synchronous to clk_sys.
    assign sclk_rise = spi_sclk && !sclk_prev;
    assign sclk_fall = !spi_sclk && sclk_prev;
    assign header_byte = {hdr_shift[6:0], spi_mosi};
    assign header_addr = header_byte[5:0];
    assign hdr_done = (state == RSB_HEADER) && sclk_rise &&
                      (bit_cnt == BIT_LAST);
    assign take_read = hdr_done && is_status_read(header_byte);

    // Register read mux, sampled once when the header completes.
    always_comb
    begin
        selected = BYTE_ZERO;
        unique case (header_addr)
            REG_WAKE_HIGH: selected = wake_timer[15:8];
            REG_WAKE_LOW: selected = wake_timer[7:0];
            REG_PKT_STATUS: selected = pkt_status;
            REG_SYNTH_DAC: selected = synth_cal_dac_readout;
            REG_TX_COUNT:
                selected = {transmit_fifo_underrun, transmit_fill_level};
            REG_RX_COUNT:
                selected = {receive_fifo_overrun, receive_fill_level};
            REG_RC_CAL_ONE: selected = {1'b0, rc_cal_result_one};
            REG_RC_CAL_ZERO: selected = {1'b0, rc_cal_result_zero};
            default: selected = BYTE_ZERO;
        endcase
    end

    // Serial port next state. Reads only copy values, so no flag or
    // count elsewhere changes because the host looked at it.
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_hdr_shift = hdr_shift;
        next_out_shift = out_shift;
        if (spi_csn)
        begin
            next_state = RSB_IDLE;
            next_bit_cnt = BIT_FIRST;
        end
        else
        begin
            unique case (state)
                RSB_IDLE:
                begin
                    next_state = RSB_HEADER;
                    next_bit_cnt = BIT_FIRST;
                end
                RSB_HEADER:
                begin
                    if (sclk_rise)
                    begin
                        next_hdr_shift = header_byte;
                        next_bit_cnt = bit_cnt + BIT_STEP;
                    end
                    // writes and foreign addresses are ignored
                    if (hdr_done)
                    begin
                        next_state = take_read ? RSB_DATA : RSB_IGNORE;
                        next_bit_cnt = BIT_FIRST;
                        if (take_read)
                        begin
                            next_out_shift = selected;
                        end
                    end
                end
                RSB_DATA:
                begin
                    // The first fall after the header must not shift,
                    // or the host would miss the top bit.
                    if (sclk_fall && (bit_cnt != BIT_FIRST))
                    begin
                        next_out_shift = {out_shift[6:0], 1'b0};
                    end
                    if (sclk_rise)
                    begin
                        next_bit_cnt = bit_cnt + BIT_STEP;
                        if (bit_cnt == BIT_LAST)
                        begin
                            next_state = RSB_IGNORE;
                        end
                    end
                end
                RSB_IGNORE:
                begin
                    next_state = RSB_IGNORE;
                end
            endcase
        end
    end

    // Serial port registers.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= RSB_IDLE;
            sclk_prev <= 1'b0;
            bit_cnt <= BIT_FIRST;
            hdr_shift <= BYTE_ZERO;
            out_shift <= BYTE_ZERO;
        end
        else
        begin
            state <= next_state;
            sclk_prev <= spi_sclk;
            bit_cnt <= next_bit_cnt;
            hdr_shift <= next_hdr_shift;
            out_shift <= next_out_shift;
        end
    end

    // The data line is driven only during a status data byte.
    assign spi_miso = out_shift[7];
    assign spi_miso_oe = (state == RSB_DATA);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_load(rsb_addr_type a);
        take_read && (header_addr == a);
    endsequence

    a_wake_high: assert property (
        s_load(REG_WAKE_HIGH) |=> out_shift == $past(wake_timer[15:8]))
        else $error("wake timer high byte wrong");

    a_wake_low: assert property (
        s_load(REG_WAKE_LOW) |=> spi_miso_oe &&
        out_shift == $past(wake_timer[7:0]))
        else $error("wake timer low byte wrong");

    a_status_outputs: assert property (
        s_load(REG_PKT_STATUS) |=>
        out_shift[2] == $past(general_output_two) &&
        out_shift[0] == $past(general_output_zero) && !out_shift[1])
        else $error("packet status output bits wrong");

    a_status_flags: assert property (
        s_load(REG_PKT_STATUS) |=>
        out_shift[7] == $past(flags.crc_ok) &&
        out_shift[3] == $past(flags.sync_found))
        else $error("packet status flags wrong");

    a_tx_count: assert property (
        s_load(REG_TX_COUNT) |=> out_shift ==
        {$past(transmit_fifo_underrun), $past(transmit_fill_level)})
        else $error("transmit count wrong");

    a_rx_count: assert property (
        s_load(REG_RX_COUNT) |=> out_shift ==
        {$past(receive_fifo_overrun), $past(receive_fill_level)})
        else $error("receive count wrong");

    a_rc_cal: assert property (
        s_load(REG_RC_CAL_ONE) |=> !out_shift[7] &&
        out_shift[6:0] == $past(rc_cal_result_one))
        else $error("calibration result wrong");

    a_dac_readout: assert property (
        s_load(REG_SYNTH_DAC) |=> out_shift == $past(synth_cal_dac_readout))
        else $error("synthesizer readout wrong");

    a_write_ignored: assert property (
        hdr_done && !header_byte[HDR_READ_BIT] && !spi_csn |=>
        !spi_miso_oe && out_shift == $past(out_shift))
        else $error("write header disturbed the bank");
endmodule

/* rsb_status_bank_tb.sv */
// Self-checking bench for the radio status bank, read through the host model.
// Assumes the bank answers one byte per frame and flags update a cycle late.
`timescale 1ns/1ps
module rsb_status_bank_tb;
    import rsb_pkg::*;

    logic clk_sys;
    logic rst;
    logic spi_csn;
    logic spi_sclk;
    logic spi_mosi;
    logic spi_miso;
    logic spi_miso_oe;
    rsb_timer_type wake_timer;
    logic [4:0] ev;
    logic crc_match, rx_mode, tx_mode, rx_ovf, tx_unf;
    logic carrier, preamble, clear_ch, out_two, out_zero;
    rsb_byte_type dac;
    logic tx_unr, rx_ovr;
    rsb_fill_type tx_fill, rx_fill, rc_one, rc_zero;
    int num_errors = 0;
    int samples_checked = 0;

    // Free-running system clock at 20 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    rsb_host_model u_host
    (
        .clk_sys(clk_sys), .spi_csn(spi_csn), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
    );

    rsb_status_bank u_dut
    (
        .clk_sys(clk_sys), .rst(rst), .spi_csn(spi_csn),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .wake_timer(wake_timer),
        .crc_check_done(ev[0]), .crc_match(crc_match), .rx_entry(ev[1]),
        .sync_word_done(ev[2]), .packet_end(ev[3]), .rx_mode(rx_mode),
        .tx_mode(tx_mode), .address_fail(ev[4]),
        .rx_overflow_state(rx_ovf), .tx_underflow_state(tx_unf),
        .carrier_sense(carrier), .preamble_quality_met(preamble),
        .channel_clear(clear_ch), .general_output_two(out_two),
        .general_output_zero(out_zero), .synth_cal_dac_readout(dac),
        .transmit_fifo_underrun(tx_unr), .transmit_fill_level(tx_fill),
        .receive_fifo_overrun(rx_ovr), .receive_fill_level(rx_fill),
        .rc_cal_result_one(rc_one), .rc_cal_result_zero(rc_zero)
    );

    // Compare one byte and count it; a mismatch is reported at once.
    task automatic check(input rsb_byte_type seen, input rsb_byte_type exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL at %0t ns: seen 0x%h expected 0x%h",
                $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", samples_checked,
            num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Burst read of one register: the bank must drive and return exp.
    task automatic rd(input rsb_addr_type a, input rsb_byte_type exp);
        rsb_byte_type d;
        logic o;
        u_host.xfer({2'b11, a}, d, o);
        check({7'h00, o}, 8'h01);
        check(d, exp);
    endtask

    // A refused header must leave the data line undriven all frame.
    task automatic refused(input rsb_byte_type hdr);
        rsb_byte_type d;
        logic o;
        u_host.xfer(hdr, d, o);
        check({7'h00, o}, 8'h00);
    endtask

    // One-cycle event pulses; the flags answer one cycle later.
    task automatic pulse(input logic [4:0] p);
        ev = p;
        u_host.step(1);
        ev = 5'h00;
        u_host.step(1);
    endtask

    // A hang in any frame is cut short well after the expected run time.
    initial
    begin
        #2000000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        rst = 1'b1;
        wake_timer = 16'ha5c3;
        ev = 5'h00;
        {crc_match, rx_mode, tx_mode, rx_ovf, tx_unf} = 5'h00;
        {carrier, preamble, clear_ch, out_two, out_zero} = 5'b10110;
        dac = 8'h96;
        {tx_unr, tx_fill, rx_ovr, rx_fill} = {1'b1, 7'h40, 1'b0, 7'h7f};
        rc_one = 7'h7f;
        rc_zero = 7'h2a;
        repeat (20) @(posedge clk_sys);
        #5;
        rst = 1'b0;
        check({7'h00, spi_miso_oe}, 8'h00);
        u_host.step(2);
        rd(REG_WAKE_HIGH, 8'ha5);
        rd(REG_WAKE_LOW, 8'hc3);
        rd(REG_SYNTH_DAC, 8'h96);
        rd(REG_TX_COUNT, 8'hc0);
        rd(REG_RX_COUNT, 8'h7f);
        rd(REG_RC_CAL_ONE, 8'h7f);
        rd(REG_RC_CAL_ZERO, 8'h2a);
        {tx_unr, tx_fill, rx_ovr, rx_fill} = {1'b0, 7'h01, 1'b1, 7'h00};
        rd(REG_TX_COUNT, 8'h01);
        rd(REG_RX_COUNT, 8'h80);
        $display("test counts done");
        rd(REG_PKT_STATUS, 8'h54);
        {out_two, out_zero} = 2'b01;
        rd(REG_PKT_STATUS, 8'h51);
        $display("test outputs done");
        crc_match = 1'b1;
        pulse(5'h01);
        rd(REG_PKT_STATUS, 8'hd1);
        pulse(5'h02);
        rd(REG_PKT_STATUS, 8'h51);
        pulse(5'h03);
        rd(REG_PKT_STATUS, 8'hd1);
        crc_match = 1'b0;
        pulse(5'h01);
        rd(REG_PKT_STATUS, 8'h51);
        $display("test checksum done");
        pulse(5'h04);
        rd(REG_PKT_STATUS, 8'h59);
        pulse(5'h08);
        rd(REG_PKT_STATUS, 8'h51);
        rx_mode = 1'b1;
        pulse(5'h04);
        pulse(5'h10);
        rd(REG_PKT_STATUS, 8'h51);
        rx_mode = 1'b0;
        pulse(5'h04);
        rx_ovf = 1'b1;
        rd(REG_PKT_STATUS, 8'h59);
        rx_mode = 1'b1;
        u_host.step(2);
        rd(REG_PKT_STATUS, 8'h51);
        {rx_mode, rx_ovf} = 2'b00;
        pulse(5'h04);
        {tx_mode, tx_unf} = 2'b11;
        u_host.step(2);
        rd(REG_PKT_STATUS, 8'h51);
        {tx_mode, tx_unf} = 2'b00;
        $display("test sync done");
        crc_match = 1'b1;
        pulse(5'h05);
        refused(8'h38);
        refused(8'hb8);
        refused(8'hf5);
        rd(REG_PKT_STATUS, 8'hd9);
        rd(REG_PKT_STATUS, 8'hd9);
        $display("test refusals done");
        report_and_stop();
    end
endmodule

/* rsb_sync_tracker.sv */
// Tracker for the checksum-match and sync-found packet status flags.
// Assumes one-cycle event pulses and level modes from the radio core.
`timescale 1ns/1ps
module rsb_sync_tracker
(
    input wire logic clk_sys,
    input wire logic rst,
    rsb_flag_if.tracker flags
);
    import rsb_pkg::*;

    logic crc_ok;
    logic sync_found;
    logic next_crc_ok;
    logic next_sync_found;
    logic early_drop;

    // Next flag values; a fresh result beats a clear in the same cycle.
    always_comb
    begin
        next_crc_ok = crc_ok;
        next_sync_found = sync_found;
        early_drop = (flags.rx_mode &&
                      (flags.address_fail || flags.rx_overflow_state)) ||
                     (flags.tx_mode && flags.tx_underflow_state);
        if (flags.crc_check_done)
        begin
            next_crc_ok = flags.crc_match;
        end
        else if (flags.rx_entry)
        begin
            next_crc_ok = 1'b0;
        end
        if (flags.sync_word_done)
        begin
            next_sync_found = 1'b1;
        end
        else if (flags.packet_end || early_drop)
        begin
            next_sync_found = 1'b0;
        end
    end

    // Flag registers, cleared by reset.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            crc_ok <= 1'b0;
            sync_found <= 1'b0;
        end
        else
        begin
            crc_ok <= next_crc_ok;
            sync_found <= next_sync_found;
        end
    end

    assign flags.crc_ok = crc_ok;
    assign flags.sync_found = sync_found;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Sync word, one cycle with no set or clear, then the packet end.
    // The quiet cycle matches how the radio core spaces these pulses.
    sequence s_sync_then_end;
        flags.sync_word_done ##1
        !(flags.sync_word_done || flags.packet_end || early_drop) ##1
        (flags.packet_end && !flags.sync_word_done);
    endsequence

    a_crc_rx_clear: assert property (
        flags.rx_entry && !flags.crc_check_done |=> !crc_ok)
        else $error("checksum flag not cleared on receive entry");

    a_crc_result: assert property (
        flags.crc_check_done |=> crc_ok == $past(flags.crc_match))
        else $error("checksum flag does not follow comparison");

    a_sync_life: assert property (
        s_sync_then_end |-> sync_found ##1 !sync_found)
        else $error("sync flag not held then dropped at packet end");

    a_sync_rx_drop: assert property (
        flags.rx_mode && (flags.address_fail || flags.rx_overflow_state)
        && !flags.sync_word_done |=> !sync_found)
        else $error("sync flag kept after receive fault");

    a_sync_tx_drop: assert property (
        flags.tx_mode && flags.tx_underflow_state
        && !flags.sync_word_done |=> !sync_found)
        else $error("sync flag kept after transmit underflow");
endmodule
